// >>> peripheral_reset_watchdog_status_bench.sv
// Bench of prw_watchdog driven by the master model.
// Short reset, tick and watchdog counts keep the run brief.
`timescale 1ns/10ps
`default_nettype none
`include "prw_regs.svh"
module peripheral_reset_watchdog_status_bench;
  localparam int unsigned RST_CY  = 2000;
  localparam int unsigned TICK_CY = 250;
  localparam int unsigned HW_CY   = 3000;
  logic        core_clk;
  logic        rstn;
  logic        kick = 1'b0;
  logic        kick_on;
  logic [1:0]  cs;
  logic [1:0]  fcs;
  logic [5:0]  kc = 6'h00;
  logic [7:0]  st;
  logic [7:0]  rp;
  logic [7:0]  per;
  logic [15:0] rx;
  int          seed;
  int          error_cnt;
  int          total_checks;
  wire         lclk;
  wire         sel_n;
  wire         mosi;
  wire         miso;
  wire         hard_rst;
  wire         soft_rst;
  wire         hw_en;
  wire         sw_en;
  wire [3:0]   outs;
  assign outs = {sw_en, hw_en, soft_rst, hard_rst};

  prw_watchdog #(
    .RESET_CYCLES (RST_CY),
    .TICK_CYCLES  (TICK_CY),
    .HW_WDT_CYCLES(HW_CY)
  ) dut_u (
    .CORE_CLK       (core_clk),
    .RSTN           (rstn),
    .LINK_CLK       (lclk),
    .LINK_SEL_N     (sel_n),
    .LINK_MOSI      (mosi),
    .LINK_MISO      (miso),
    .HW_WDT_KICK    (kick),
    .CARD_STATUS    (cs),
    .CARD_HARD_RESET(hard_rst),
    .CPU_SOFT_RESET (soft_rst),
    .HW_WDT_ENABLED (hw_en),
    .SW_WDT_ENABLED (sw_en)
  );
  prw_master_model mst_u (
    .link_clk  (lclk),
    .link_sel_n(sel_n),
    .link_mosi (mosi),
    .link_miso (miso)
  );

  // Core clock, 4 ns
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Card refresh of the hardware watchdog every 64 cycles
  always @(posedge core_clk) begin
    kc   <= kc + 6'h01;
    kick <= kick_on && (kc == 6'h00);
  end

  // Expected status byte; flags are busy, error, unexecuted, expired
  function automatic logic [7:0] exp_st(input logic [3:0] f);
    return {f[3] ? `PRW_ST_BUSY : `PRW_ST_READY, `PRW_ST_ROUTER, f[2],
            fcs, f[1], f[0]};
  endfunction

  // Byte and flag comparisons
  task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
    total_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic chk1(input logic act, input logic exp);
    chk8({7'h00, act}, {7'h00, exp});
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Bounded wait for one output to reach a level
  task automatic wait_for(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (outs[idx] !== val) begin
      @(posedge core_clk);
      n++;
      if (n > lim) begin
        error_cnt++;
        $display("ERROR %0t wait timed out", $time);
        summarize();
      end
    end
  endtask

  // One frame with fresh card bits and a random idle gap
  task automatic go(input logic [7:0] c, input logic [7:0] a, input int nb);
    @(posedge core_clk);
    cs <= 2'($random(seed));
    repeat (10 + $unsigned($random(seed)) % 16) @(posedge core_clk);
    fcs = cs;
    mst_u.xfer(c, a, nb, rx);
    st = rx[15:8];
    rp = rx[7:0];
  endtask

  // Main sequence
  initial begin
    seed = 32'ha599;
    error_cnt = 0;
    total_checks = 0;
    rstn = 1'b0;
    kick_on = 1'b1;
    cs = 2'h0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk8({4'h0, outs}, 8'h00);
    go(8'h05, 8'h00, 16);
    chk8(st, exp_st(4'h0));
    go(8'h06, 8'h00, 16);
    chk8(rp, 8'h80);
    go(8'h05, 8'h00, 16);
    chk8(rp, 8'h00);
    go(8'h07, 8'h00, 16);
    chk8(rp, 8'h00);
    per = 8'h10 + 8'($unsigned($random(seed)) % 16);
    go(8'h02, per, 16);
    chk8(st, exp_st(4'h6));
    go(8'h03, 8'h02, 16);
    chk8(st, exp_st(4'h4));
    chk8({4'h0, outs}, 8'h08);
    go(8'h04, 8'h00, 16);
    chk8(rp, 8'h00);
    $display("test 1 done");
    go(8'h04, 8'h00, 16);
    chk1(rp <= per && rp + 8'h06 >= per, 1'b1);
    go(8'h03, 8'h00, 16);
    chk1(rp <= per && rp + 8'h06 >= per, 1'b1);
    chk8({4'h0, outs}, 8'h0c);
    go(8'h03, 8'h01, 16);
    chk1(hw_en, 1'b1);
    wait_for(1, 1'b1, (int'(per) + 8) * TICK_CY);
    chk1(hard_rst, 1'b0);
    wait_for(1, 1'b0, RST_CY + 20);
    go(8'h05, 8'h00, 16);
    chk8(st, exp_st(4'h5));
    go(8'h02, 8'h00, 16);
    chk8(rp, 8'h70);
    chk8(st, exp_st(4'h4));
    chk1(sw_en, 1'b0);
    $display("test 2 done");
    go(8'h01, 8'h01, 16);
    chk8({4'h0, outs}, 8'h06);
    go(8'h06, 8'h00, 16);
    chk8(st, exp_st(4'hc));
    wait_for(1, 1'b0, RST_CY + 20);
    go(8'h06, 8'h00, 16);
    chk8(st, exp_st(4'h6));
    go(8'h05, 8'h00, 16);
    chk8(rp, 8'h48);
    go(8'h05, 8'h00, 16);
    chk8(rp, 8'h60);
    $display("test 3 done");
    kick_on = 1'b0;
    wait_for(0, 1'b1, HW_CY + 100);
    wait_for(0, 1'b0, RST_CY + 20);
    chk1(hw_en, 1'b0);
    kick_on = 1'b1;
    repeat (100) @(posedge core_clk); // Settle gap
    go(8'h05, 8'h00, 16);
    chk8(st, exp_st(4'h1));
    go(8'h01, 8'h00, 16);
    chk8(rp, 8'h80);
    chk1(hard_rst, 1'b1);
    wait_for(0, 1'b0, RST_CY + 20);
    repeat (100) @(posedge core_clk); // Settle gap
    $display("test 4 done");
    go(8'h05, 8'h00, 8);
    go(8'h06, 8'h00, 16);
    chk8(st, exp_st(4'h4));
    go(8'h05, 8'h00, 16);
    chk8(rp, 8'h10);
    $display("test 5 done");
    summarize();
  end
endmodule // peripheral_reset_watchdog_status_bench
`default_nettype wire

// >>> prw_master_model.sv
// Master of the serial link: select, 160 ns clock and command bytes.
// Clock stands still outside frames; the bench calls xfer.
`timescale 1ns/10ps
`default_nettype none
module prw_master_model (
  // Serial link to the card
  output var logic link_clk,
  output var logic link_sel_n,
  output var logic link_mosi,
  input  wire logic link_miso
);
  // Idle levels at time zero
  initial begin
    link_clk   = 1'b0;
    link_sel_n = 1'b1;
    link_mosi  = 1'b0;
  end

  // Select, then bits MSB first with the clock; MISO read in low phase
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] arg,
                      input int nbits, output logic [15:0] rx);
    logic [15:0] tx;
    tx = {cmd, arg};
    rx = 16'h0000;
    #1.3;
    link_sel_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      link_mosi = (i < 16) ? tx[15 - i] : 1'b0;
      #40;
      if (i < 16) begin
        rx[15 - i] = link_miso;
      end
      #40;
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
    end
    #80;
    link_sel_n = 1'b1;
    link_mosi  = ~link_mosi; // Released line holds no stale value
    #400;
  endtask
endmodule // prw_master_model
`default_nettype wire

// >>> prw_pkg.sv
// Types of the card reset, watchdog and status block.
// Assumes the constants of prw_regs.svh.
package prw_pkg;

  // Sequencer of the card
  typedef enum logic [1:0] {
    PRW_RUN,
    PRW_HARD,
    PRW_SOFT
  } prw_state_type;

  // Core clock domain state
  typedef struct packed {
    logic [1:0]    sync_cmd;
    logic [1:0]    sync_err;
    logic [1:0]    sync_sel;
    logic          seen_cmd;
    logic          seen_err;
    logic          sel_prev;
    logic          frame_cmd;
    prw_state_type state;
    logic [27:0]   seq_cnt;
    logic [27:0]   tick_cnt;
    logic [27:0]   hw_cnt;
    logic          hw_en;
    logic          sw_en;
    logic [7:0]    period;
    logic [7:0]    sw_cnt;
    logic          cause_hw;
    logic          cause_sw;
    logic          wdt_expired;
    logic [7:3]    link_err;
    logic          last_unexec;
    logic          post_pend;
    logic [7:0]    reply;
    logic [7:0]    tx_status;
    logic [7:0]    tx_reply;
    logic          hard_out;
    logic          soft_out;
  } prw_core_type;

  // Link clock state that lives only for one frame
  typedef struct packed {
    logic [5:0]  bit_cnt;
    logic [14:0] shreg;
  } prw_frame_type;

  // Link clock state kept across frames
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] arg;
    logic       cmd_tgl;
    logic       err_tgl;
  } prw_keep_type;

endpackage

// >>> prw_regs.svh
// Constants of the card reset, watchdog and status block: command codes,
// bit positions of the status bytes and timing figures.
// Assumes a 250 MHz core clock and a one-command-per-frame serial link.
`ifndef PRW_REGS_SVH
`define PRW_REGS_SVH

// Command codes, first byte of a frame
`define PRW_CMD_CARD_RESET      8'h01
`define PRW_CMD_SOFT_PERIOD     8'h02
`define PRW_CMD_WDT_ENABLE      8'h03
`define PRW_CMD_SOFT_REFRESH    8'h04
`define PRW_CMD_RESET_CAUSE     8'h05
`define PRW_CMD_LINK_ERROR      8'h06

// Reset kinds and watchdog enable selectors
`define PRW_KIND_HARD           8'h00
`define PRW_KIND_SOFT           8'h01
`define PRW_WDT_BOTH            8'h00
`define PRW_WDT_HW_ONLY         8'h01
`define PRW_WDT_SW_ONLY         8'h02

// Reset-cause register bits
`define PRW_CAUSE_HW_RESET      7
`define PRW_CAUSE_SW_RESET      6
`define PRW_CAUSE_HW_WDT_EN     5
`define PRW_CAUSE_SW_WDT_EN     4

// Link-error register bits
`define PRW_ERR_DATA_WAIT       7
`define PRW_ERR_COLLISION       6
`define PRW_ERR_OVERRUN         5
`define PRW_ERR_MODE_FAULT      4
`define PRW_ERR_COMPARE         3

// Command status byte fields
`define PRW_ST_READY            2'h1
`define PRW_ST_BUSY             2'h2
`define PRW_ST_ROUTER           1'h0
`define PRW_STB_LINK_ERR        4
`define PRW_STB_UNEXEC          1
`define PRW_STB_WDT_EXP         0

// Frame length in link clock bits
`define PRW_FRAME_BITS          16
`define PRW_OVERRUN_BITS        32

// Timing: core clock in kHz, times in ms, counts derived
`define PRW_CLK_KHZ             250000
`define PRW_RESET_MS            25
`define PRW_TICK_MS             25
`define PRW_HW_WDT_MS           1000
`define PRW_RESET_CYCLES        (`PRW_RESET_MS * `PRW_CLK_KHZ)
`define PRW_TICK_CYCLES         (`PRW_TICK_MS * `PRW_CLK_KHZ)
`define PRW_HW_WDT_CYCLES       (`PRW_HW_WDT_MS * `PRW_CLK_KHZ)

`endif

// >>> prw_watchdog.sv
// Reset sequencer, hardware and software watchdogs, clear-on-read cause and
// link-error registers and command status byte of a serial peripheral card.
// Assumes a master that drives select, serial clock and data, one command of
// two bytes per frame, with the serial clock stopped outside frames.
`timescale 1ns/10ps
`default_nettype none
`include "prw_regs.svh"

// Function
// [R1] A reset command runs a 25 ms reset sequence, then the card resumes.
// [R2] Master waits 1.5 s after the reset ends before addressing the card.
// [R3] Kind 0 is a hard reset of all logic; kind 1 resets processor only.
// [R4] Software watchdog period is 0.025 to 6.375 s in 0.025 s steps.
// [R5] A zero software watchdog period disables the software watchdog.
// [R6] Enable selector: 0 both, 1 hardware only, 2 software only.
// [R7] Card refreshes hardware watchdog itself; expiry causes a hard reset.
// [R8] Hardware watchdog stays enabled until a hard reset.
// [R9] Master refreshes the software watchdog before its period runs out.
// [R10] Software watchdog expiry without refresh causes a soft reset.
// [R11] Master programs period, then enables, then refreshes.
// [R12] A refresh returns the present count, each count being 25 ms.
// [R13] Reset-cause byte: hw reset, sw reset, hw wdt on, sw wdt on; read clears.
// [R14] Link-error byte: waiting, collision, overrun, fault, compare; read clears.
// [R15] Status byte returned reports the previous command's outcome.
// [R16] Status bits 7:6 are 01 ready, 10 busy, 11 not connected.
// [R17] Status bit 5 is 0 for an end device, 1 for a router.
// [R18] Status bit 4 is set while any link error is flagged.
// [R19] Status bits 3:2 are left for card-specific use.
// [R20] Status bit 1 is 0 when last command accepted, 1 when unexecuted.
// [R21] Status bit 0 is set when either watchdog has expired.
// [R22] Master asserts select, then sends bytes with its clock.
// [R23] Software count loads in 25 ms units, decrements per tick, reloads.
module prw_watchdog #(
  parameter int unsigned RESET_CYCLES  = `PRW_RESET_CYCLES,
  parameter int unsigned TICK_CYCLES   = `PRW_TICK_CYCLES,
  parameter int unsigned HW_WDT_CYCLES = `PRW_HW_WDT_CYCLES
) (
  // Core clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  // Serial link from the master
  input  wire logic       LINK_CLK,
  input  wire logic       LINK_SEL_N,
  input  wire logic       LINK_MOSI,
  output logic            LINK_MISO,
  // Card side
  input  wire logic       HW_WDT_KICK,
  input  wire logic [1:0] CARD_STATUS,
  output logic            CARD_HARD_RESET,
  output logic            CPU_SOFT_RESET,
  output logic            HW_WDT_ENABLED,
  output logic            SW_WDT_ENABLED
);

  prw_pkg::prw_core_type  core;
  prw_pkg::prw_core_type  next_core;
  prw_pkg::prw_frame_type frame;
  prw_pkg::prw_frame_type next_frame;
  prw_pkg::prw_keep_type  keep;
  prw_pkg::prw_keep_type  next_keep;
  logic                   frame_rst_n;

  // Frame state is held cleared while select is high
  assign frame_rst_n = RSTN & ~LINK_SEL_N; // [R22]

  // Link side: shift in command and argument, count the bits of a frame
  always_comb begin
    next_frame = frame;
    next_keep  = keep;
    next_frame.shreg = {frame.shreg[13:0], LINK_MOSI};
    if (frame.bit_cnt != 6'(`PRW_OVERRUN_BITS + 1)) begin
      next_frame.bit_cnt = frame.bit_cnt + 6'h01;
    end
    // Sixteenth bit completes the command bytes
    if (frame.bit_cnt == 6'(`PRW_FRAME_BITS - 1)) begin
      next_keep.cmd     = frame.shreg[14:7];
      next_keep.arg     = {frame.shreg[6:0], LINK_MOSI};
      next_keep.cmd_tgl = ~keep.cmd_tgl;
    end
    // A frame reaching the last bit of its second word is an overrun
    if (frame.bit_cnt == 6'(`PRW_OVERRUN_BITS - 1)) begin
      next_keep.err_tgl = ~keep.err_tgl;
    end
  end

  // Frame registers, cleared by select between frames
  always_ff @(posedge LINK_CLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // Captured command and event toggles, kept across frames
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      keep <= '0;
    end else begin
      keep <= next_keep;
    end
  end

  // Status byte first, then the reply of the previous command
  always_comb begin
    if (frame.bit_cnt < 6'h08) begin
      LINK_MISO = core.tx_status[3'h7 - frame.bit_cnt[2:0]]; // [R15]
    end else if (frame.bit_cnt < 6'(`PRW_FRAME_BITS)) begin
      LINK_MISO = core.tx_reply[3'h7 - frame.bit_cnt[2:0]];
    end else begin
      LINK_MISO = 1'b0;
    end
  end

  // Core side: command execution, watchdogs and reset sequencing
  always_comb begin
    logic       new_cmd;
    logic       new_err;
    logic       frame_end;
    logic       unexec;
    logic       go_hard;
    logic       go_soft;
    logic       tick;
    logic [7:0] cause_byte;
    logic [7:0] err_byte;
    new_cmd    = 1'b0;
    new_err    = 1'b0;
    frame_end  = 1'b0;
    unexec     = 1'b0;
    go_hard    = 1'b0;
    go_soft    = 1'b0;
    tick       = 1'b0;
    cause_byte = 8'h00;
    err_byte   = 8'h00;
    next_core  = core;

    // Synchronisers; only the second stage is looked at
    next_core.sync_cmd = {core.sync_cmd[0], keep.cmd_tgl};
    next_core.sync_err = {core.sync_err[0], keep.err_tgl};
    next_core.sync_sel = {core.sync_sel[0], LINK_SEL_N};
    new_cmd   = core.sync_cmd[1] != core.seen_cmd;
    new_err   = core.sync_err[1] != core.seen_err;
    frame_end = core.sync_sel[1] & ~core.sel_prev;
    next_core.seen_cmd = core.sync_cmd[1];
    next_core.seen_err = core.sync_err[1];
    next_core.sel_prev = core.sync_sel[1];

    // Register images
    cause_byte[`PRW_CAUSE_HW_RESET]  = core.cause_hw; // [R13]
    cause_byte[`PRW_CAUSE_SW_RESET]  = core.cause_sw;
    cause_byte[`PRW_CAUSE_HW_WDT_EN] = core.hw_en;
    cause_byte[`PRW_CAUSE_SW_WDT_EN] = core.sw_en;
    err_byte[7:3] = core.link_err; // [R14]

    // Command decode, only while the card runs
    if (new_cmd) begin
      next_core.frame_cmd = 1'b1;
      if (core.post_pend) begin
        next_core.link_err[`PRW_ERR_DATA_WAIT] = 1'b1;
      end
      if (core.state != prw_pkg::PRW_RUN) begin
        unexec = 1'b1;
        next_core.link_err[`PRW_ERR_COLLISION] = 1'b1;
      end else begin
        case (keep.cmd)
          `PRW_CMD_CARD_RESET: begin
            if (keep.arg == `PRW_KIND_HARD) begin
              go_hard = 1'b1; // [R3]
            end else if (keep.arg == `PRW_KIND_SOFT) begin
              go_soft = 1'b1; // [R3]
            end else begin
              unexec = 1'b1;
            end
          end
          `PRW_CMD_SOFT_PERIOD: begin
            next_core.period = keep.arg; // [R4]
            next_core.sw_cnt = keep.arg; // [R23]
            next_core.tick_cnt = '0;
            if (keep.arg == 8'h00) begin
              next_core.sw_en = 1'b0; // [R5]
            end
          end
          `PRW_CMD_WDT_ENABLE: begin
            next_core.sw_cnt   = core.period; // [R23]
            next_core.tick_cnt = '0;
            case (keep.arg)
              `PRW_WDT_BOTH: begin
                next_core.hw_en = 1'b1; // [R6]
                next_core.sw_en = core.period != 8'h00; // [R5]
              end
              `PRW_WDT_HW_ONLY: begin
                next_core.hw_en = 1'b1; // [R6]
              end
              `PRW_WDT_SW_ONLY: begin
                next_core.sw_en = core.period != 8'h00; // [R6]
              end
              default: begin
                unexec = 1'b1;
              end
            endcase
          end
          `PRW_CMD_SOFT_REFRESH: begin
            if (core.sw_en) begin
              next_core.reply    = core.sw_cnt; // [R12]
              next_core.sw_cnt   = core.period; // [R23]
              next_core.tick_cnt = '0;
            end else begin
              unexec = 1'b1;
            end
          end
          `PRW_CMD_RESET_CAUSE: begin
            next_core.reply       = cause_byte;
            next_core.cause_hw    = 1'b0; // [R13]
            next_core.cause_sw    = 1'b0;
            next_core.wdt_expired = 1'b0;
          end
          `PRW_CMD_LINK_ERROR: begin
            next_core.reply    = err_byte;
            next_core.link_err = '0; // [R14]
          end
          default: begin
            unexec = 1'b1;
            next_core.link_err[`PRW_ERR_COMPARE] = 1'b1;
          end
        endcase
      end
      next_core.last_unexec = unexec; // [R20]
      next_core.post_pend   = 1'b1;
    end

    // Overrun and mode fault set after any read clear, so a read never loses them
    if (new_err) begin
      next_core.link_err[`PRW_ERR_OVERRUN] = 1'b1;
    end
    if (frame_end) begin
      next_core.frame_cmd = 1'b0;
      if (!core.frame_cmd && !new_cmd) begin
        next_core.link_err[`PRW_ERR_MODE_FAULT] = 1'b1;
      end
    end

    // Watchdogs while the card runs
    if (core.state == prw_pkg::PRW_RUN) begin
      if (core.tick_cnt == 28'(TICK_CYCLES - 1)) begin
        next_core.tick_cnt = '0;
        tick = 1'b1;
      end else if (!(new_cmd && keep.cmd == `PRW_CMD_SOFT_REFRESH)) begin
        next_core.tick_cnt = core.tick_cnt + 28'h1;
      end
      // Software count steps down once per 25 ms tick
      if (core.sw_en && tick && !new_cmd) begin
        if (core.sw_cnt <= 8'h01) begin
          next_core.wdt_expired = 1'b1; // [R21]
          go_soft = 1'b1; // [R10]
        end else begin
          next_core.sw_cnt = core.sw_cnt - 8'h01; // [R23]
        end
      end
      // Hardware watchdog kicked by the card itself
      if (core.hw_en) begin
        if (HW_WDT_KICK) begin
          next_core.hw_cnt = '0; // [R7]
        end else if (core.hw_cnt == 28'(HW_WDT_CYCLES - 1)) begin
          next_core.hw_cnt = '0;
          next_core.wdt_expired = 1'b1; // [R21]
          go_hard = 1'b1; // [R7]
        end else begin
          next_core.hw_cnt = core.hw_cnt + 28'h1;
        end
      end
    end

    // Reset sequencer
    case (core.state)
      prw_pkg::PRW_RUN: begin
        if (go_hard) begin
          // Hard reset clears watchdogs, period, counts and link errors, sets cause_hw and keeps cause_sw
          next_core.state    = prw_pkg::PRW_HARD;
          next_core.seq_cnt  = '0;
          next_core.hw_en    = 1'b0; // [R8]
          next_core.sw_en    = 1'b0;
          next_core.period   = 8'h00;
          next_core.sw_cnt   = 8'h00;
          next_core.hw_cnt   = '0;
          next_core.tick_cnt = '0;
          next_core.link_err = '0;
          next_core.cause_hw = 1'b1; // [R13]
          next_core.hard_out = 1'b1; // [R3]
        end else if (go_soft) begin
          next_core.state    = prw_pkg::PRW_SOFT;
          next_core.seq_cnt  = '0;
          next_core.sw_cnt   = core.period;
          next_core.tick_cnt = '0;
          next_core.cause_sw = 1'b1; // [R13]
          next_core.soft_out = 1'b1; // [R3]
        end
      end
      prw_pkg::PRW_HARD,
      prw_pkg::PRW_SOFT: begin
        if (core.seq_cnt == 28'(RESET_CYCLES - 1)) begin
          next_core.state    = prw_pkg::PRW_RUN; // [R1]
          next_core.hard_out = 1'b0;
          next_core.soft_out = 1'b0;
        end else begin
          next_core.seq_cnt = core.seq_cnt + 28'h1; // [R1]
        end
      end
      default: begin
        next_core.state = prw_pkg::PRW_RUN;
      end
    endcase

    // Answer bytes change only between frames
    if (core.sync_sel[1]) begin
      next_core.post_pend = new_cmd;
      next_core.tx_reply  = core.reply;
      if (core.state == prw_pkg::PRW_RUN) begin
        next_core.tx_status[7:6] = `PRW_ST_READY; // [R16]
      end else begin
        next_core.tx_status[7:6] = `PRW_ST_BUSY; // [R16]
      end
      next_core.tx_status[5] = `PRW_ST_ROUTER; // [R17]
      next_core.tx_status[`PRW_STB_LINK_ERR] = |core.link_err; // [R18]
      next_core.tx_status[3:2] = CARD_STATUS; // [R19]
      next_core.tx_status[`PRW_STB_UNEXEC]  = core.last_unexec; // [R20]
      next_core.tx_status[`PRW_STB_WDT_EXP] = core.wdt_expired; // [R21]
    end
  end

  // Core registers; power-up counts as a hard reset
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      core          <= '0;
      core.sync_sel <= 2'h3;
      core.sel_prev <= 1'b1;
      core.state    <= prw_pkg::PRW_RUN;
      core.cause_hw <= 1'b1;
      core.tx_status <= {`PRW_ST_READY, 6'h00};
    end else begin
      core <= next_core;
    end
  end

  // Card-side outputs
  assign CARD_HARD_RESET = core.hard_out;
  assign CPU_SOFT_RESET  = core.soft_out | core.hard_out;
  assign HW_WDT_ENABLED  = core.hw_en;
  assign SW_WDT_ENABLED  = core.sw_en;

endmodule // prw_watchdog

`default_nettype wire

// >>> prw_watchdog_props.sv
// Checker of the reset and watchdog outputs of prw_watchdog.
// Bound to the design; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module prw_watchdog_props #(
  parameter int unsigned RESET_CYCLES  = 20,
  parameter int unsigned HW_WDT_CYCLES = 200
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Card side
  input wire logic HW_WDT_KICK,
  input wire logic CARD_HARD_RESET,
  input wire logic CPU_SOFT_RESET,
  input wire logic HW_WDT_ENABLED,
  input wire logic SW_WDT_ENABLED
);
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  int unsigned seq_len;
  int unsigned idle_len;

  // Sequence length and cycles since the last kick
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      seq_len  <= 0;
      idle_len <= 0;
    end else begin
      seq_len  <= CPU_SOFT_RESET ? seq_len + 1 : 0;
      idle_len <= (HW_WDT_ENABLED && !HW_WDT_KICK && !CPU_SOFT_RESET) ?
                  idle_len + 1 : 0;
    end
  end

  property p_hard_in_soft;
    CARD_HARD_RESET |-> CPU_SOFT_RESET;
  endproperty
  a_hard_in_soft: assert property (p_hard_in_soft)
    else $error("hard reset without processor reset");
  property p_seq_len;
    $fell(CPU_SOFT_RESET) |->
      seq_len >= RESET_CYCLES - 1 && seq_len <= RESET_CYCLES + 2;
  endproperty
  a_seq_len: assert property (p_seq_len)
    else $error("reset sequence length wrong");
  property p_seq_cap;
    seq_len <= RESET_CYCLES + 2;
  endproperty
  a_seq_cap: assert property (p_seq_cap)
    else $error("reset sequence too long");
  property p_hw_expiry;
    idle_len <= HW_WDT_CYCLES + 4;
  endproperty
  a_hw_expiry: assert property (p_hw_expiry)
    else $error("hardware watchdog did not expire");
  property p_hw_sticky;
    $fell(HW_WDT_ENABLED) |-> CARD_HARD_RESET || $past(CARD_HARD_RESET);
  endproperty
  a_hw_sticky: assert property (p_hw_sticky)
    else $error("hardware watchdog off without hard reset");
  property p_hard_clears;
    $rose(CARD_HARD_RESET) |-> ##2 !HW_WDT_ENABLED && !SW_WDT_ENABLED;
  endproperty
  a_hard_clears: assert property (p_hard_clears)
    else $error("hard reset kept a watchdog on");
  property p_soft_only;
    $rose(CPU_SOFT_RESET) && !CARD_HARD_RESET |=> !CARD_HARD_RESET [*8];
  endproperty
  a_soft_only: assert property (p_soft_only)
    else $error("soft reset turned hard");
  property p_hard_end;
    $fell(CARD_HARD_RESET) |-> ##[0:1] !CPU_SOFT_RESET;
  endproperty
  a_hard_end: assert property (p_hard_end)
    else $error("processor reset outlasts hard reset");
  property p_en_idle;
    $rose(HW_WDT_ENABLED) || $rose(SW_WDT_ENABLED) |-> !CPU_SOFT_RESET;
  endproperty
  a_en_idle: assert property (p_en_idle)
    else $error("watchdog enabled while busy");

  // Main scenarios
  c_hard: cover property ($rose(CARD_HARD_RESET));
  c_soft: cover property ($rose(CPU_SOFT_RESET) && !CARD_HARD_RESET);
  c_sw_on: cover property ($rose(SW_WDT_ENABLED));
  c_hw_off: cover property ($fell(HW_WDT_ENABLED));
endmodule // prw_watchdog_props

bind prw_watchdog prw_watchdog_props #(
  .RESET_CYCLES (RESET_CYCLES),
  .HW_WDT_CYCLES(HW_WDT_CYCLES)
) props_u (
  .CORE_CLK       (CORE_CLK),
  .RSTN           (RSTN),
  .HW_WDT_KICK    (HW_WDT_KICK),
  .CARD_HARD_RESET(CARD_HARD_RESET),
  .CPU_SOFT_RESET (CPU_SOFT_RESET),
  .HW_WDT_ENABLED (HW_WDT_ENABLED),
  .SW_WDT_ENABLED (SW_WDT_ENABLED)
);
`default_nettype wire
